/* File: core/tpe_poison_status.v */
/*
 * tlp poison handling and error status registers for an endpoint
 * transaction layer. receive path is forwarded to the application
 * untouched; transmit path carries application and config tlps out.
 * assumes single clock, inputs synchronous to clk_sys_in, one header
 * dword per valid strobe, and a well-behaved avalon-mm master.
 *
 * register map, 32-bit words at byte offsets:
 *   0x0  command in [15:0], read/write; status in [31:16], where
 *        bit 24 is master data parity error and bit 31 is detected
 *        parity error, both write-one-to-clear
 *   0x4  uncorrectable error status, write-one-to-clear
 *   0x8  correctable error status, write-one-to-clear
 *   0xc  data of the last config write performed, read only
 * the bus answers every access after exactly one wait cycle.
 * the application must not offer a tx tlp in a cycle where config
 * space logic sends: config traffic wins and the other is lost.
 * error event inputs are one-cycle pulses, one bit per condition.
 */
`timescale 1ns/100ps
`include "tpe_consts.vh"

module tpe_poison_status (
	input wire clk_sys_in,
	input wire rst_n_in,
	// avalon-mm slave
	input wire [3:0] avs_address_in,
	input wire avs_read_in,
	input wire avs_write_in,
	input wire [31:0] avs_writedata_in,
	input wire [3:0] avs_byteenable_in,
	output reg [31:0] avs_readdata_out,
	output reg avs_waitrequest_out,
	// receive side from link
	input wire rx_valid_in,
	input wire [31:0] rx_hdr_in,
	input wire [31:0] rx_data_in,
	// receive side to application
	output reg rx_valid_out,
	output reg [31:0] rx_hdr_out,
	output reg [31:0] rx_data_out,
	output reg rx_poisoned_out,
	// config write sink
	output reg cfg_wr_out,
	output reg [31:0] cfg_wr_data_out,
	// transmit from application
	input wire app_tx_valid_in,
	input wire [31:0] app_tx_hdr_in,
	input wire [31:0] app_tx_data_in,
	// transmit from config space logic
	input wire cfg_tx_valid_in,
	input wire [31:0] cfg_tx_hdr_in,
	input wire [31:0] cfg_tx_data_in,
	// transmit to link
	output reg tx_valid_out,
	output reg [31:0] tx_hdr_out,
	output reg [31:0] tx_data_out,
	// error detection events
	input wire [`TPE_UNCOR_W-1:0] uncor_evt_in,
	input wire [`TPE_COR_W-1:0] cor_evt_in,
	// status copies
	output reg par_en_out,
	output reg [`TPE_UNCOR_W-1:0] uncor_stat_out,
	output reg [`TPE_COR_W-1:0] cor_stat_out
);

	reg [31:0] cmd_reg;
	reg [31:0] cfg_data_reg;
	reg dpe_reg;
	reg mdpe_reg;
	reg [`TPE_UNCOR_W-1:0] uncor_reg;
	reg [`TPE_COR_W-1:0] cor_reg;

	// bus handshake states, one-hot
	localparam [1:0] ST_IDLE = 2'h1;
	localparam [1:0] ST_ACK = 2'h2;
	reg [1:0] bus_state_reg;
	reg [1:0] bus_state_next;
	wire bus_ack;
	wire uncor_clr_hit;
	wire cor_clr_hit;
	genvar gi;

	wire rx_poison;
	wire rx_is_cpl;
	wire rx_is_cfgwr;
	wire tx_sel_cfg;
	wire [31:0] tx_hdr_sel;
	wire tx_is_wrreq;
	wire tx_poison;
	wire wr_hit;
	wire [31:0] wmask;
	wire [31:0] wclr;
	reg [31:0] rd_mux;

	assign rx_poison = rx_valid_in & rx_hdr_in[`TPE_HDR_POISON];
	assign rx_is_cpl = rx_hdr_in[`TPE_HDR_TYPE_HI:`TPE_HDR_TYPE_LO] == `TPE_TYPE_CPL;
	// fmt bit 30 set means request with data, i.e. a write
	assign rx_is_cfgwr = rx_hdr_in[30] &
		((rx_hdr_in[`TPE_HDR_TYPE_HI:`TPE_HDR_TYPE_LO] == `TPE_TYPE_CFG_LO) |
		(rx_hdr_in[`TPE_HDR_TYPE_HI:`TPE_HDR_TYPE_LO] == `TPE_TYPE_CFG_HI));

	// config responses take priority; an application tlp in the same cycle is dropped
	assign tx_sel_cfg = cfg_tx_valid_in;
	// force poison clear on config tlps
	assign tx_hdr_sel = tx_sel_cfg ?
		(cfg_tx_hdr_in & ~(32'h00000001 << `TPE_HDR_POISON)) : app_tx_hdr_in;
	assign tx_is_wrreq = tx_hdr_sel[30] &
		((tx_hdr_sel[`TPE_HDR_TYPE_HI:`TPE_HDR_TYPE_LO] == `TPE_TYPE_MEM) |
		(tx_hdr_sel[`TPE_HDR_TYPE_HI:`TPE_HDR_TYPE_LO] == `TPE_TYPE_IO));
	assign tx_poison = (tx_sel_cfg | app_tx_valid_in) & tx_hdr_sel[`TPE_HDR_POISON];

	// byte-enable mask for writes
	assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
		{8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
	// writes land on the first edge of an access only; the second
	// edge of the same access must not apply the strobe again
	assign bus_ack = bus_state_reg == ST_ACK;
	assign wr_hit = avs_write_in & ~bus_ack;
	assign wclr = wr_hit ? (avs_writedata_in & wmask) : 32'h00000000;
	// per-register clear selects
	assign uncor_clr_hit = avs_address_in == `TPE_OFS_UNCOR;
	assign cor_clr_hit = avs_address_in == `TPE_OFS_COR;

	// read data mux; unmapped offsets read zero
	// status half of word 0 is rebuilt from the sticky flags, so
	// reserved status bits always read zero whatever was written
	always @* begin
		case (avs_address_in)
		`TPE_OFS_CMD_STAT: rd_mux = {dpe_reg, 6'h00, mdpe_reg, 8'h00, cmd_reg[15:0]};
		`TPE_OFS_UNCOR: rd_mux = {11'h000, uncor_reg};
		`TPE_OFS_COR: rd_mux = {16'h0000, cor_reg};
		`TPE_OFS_CFG_DATA: rd_mux = cfg_data_reg;
		default: rd_mux = 32'h00000000;
		endcase
	end

	// handshake next state: idle takes a request, ack lasts one cycle
	// so a held request is not taken twice
	always @* begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
		ST_IDLE: begin
			if (avs_read_in | avs_write_in)
				bus_state_next = ST_ACK;
		end
		ST_ACK: begin
			bus_state_next = ST_IDLE;
		end
		default: begin
			bus_state_next = ST_IDLE;
		end
		endcase
	end

	// bus handshake: one wait cycle, answer on the second edge
	// waitrequest is registered, so it idles high and drops only in
	// the ack cycle; readdata is loaded in step with it
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bus_state_reg <= ST_IDLE;
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h00000000;
		end else begin
			bus_state_reg <= bus_state_next;
			avs_waitrequest_out <= bus_state_next != ST_ACK;
			avs_readdata_out <= rd_mux;
		end
	end

	// command register and config data, plus sticky status
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmd_reg <= `TPE_RST_CMD;
			cfg_data_reg <= `TPE_RST_CFG;
			dpe_reg <= 1'b0;
			mdpe_reg <= 1'b0;
			cfg_wr_out <= 1'b0;
			cfg_wr_data_out <= 32'h00000000;
		end else begin
			if (wr_hit && avs_address_in == `TPE_OFS_CMD_STAT)
				cmd_reg[15:0] <= (cmd_reg[15:0] & ~wmask[15:0]) |
					(avs_writedata_in[15:0] & wmask[15:0]);
			cfg_wr_out <= rx_valid_in & rx_is_cfgwr & ~rx_poison;
			if (rx_valid_in && rx_is_cfgwr && !rx_poison) begin
				cfg_data_reg <= rx_data_in;
				cfg_wr_data_out <= rx_data_in;
			end
			dpe_reg <= rx_poison | (dpe_reg &
				~((avs_address_in == `TPE_OFS_CMD_STAT) & wclr[`TPE_BIT_DPE]));
			mdpe_reg <= (cmd_reg[`TPE_BIT_PAR_EN] &
				((rx_poison & rx_is_cpl) | (tx_poison & tx_is_wrreq))) |
				(mdpe_reg & ~((avs_address_in == `TPE_OFS_CMD_STAT) &
				wclr[`TPE_BIT_MDPE]));
		end
	end

	// event beats clear, per bit
	// each bit is its own flop so a clear of one never disturbs another
	generate
		for (gi = 0; gi < `TPE_UNCOR_W; gi = gi + 1) begin : g_uncor
			always @(posedge clk_sys_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					uncor_reg[gi] <= 1'b0;
				end else begin
					uncor_reg[gi] <= uncor_evt_in[gi] |
						(uncor_reg[gi] & ~(uncor_clr_hit & wclr[gi]));
				end
			end
		end
	endgenerate

	// correctable write-1 clear
	// same sticky cell as above, narrower register
	generate
		for (gi = 0; gi < `TPE_COR_W; gi = gi + 1) begin : g_cor
			always @(posedge clk_sys_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					cor_reg[gi] <= 1'b0;
				end else begin
					cor_reg[gi] <= cor_evt_in[gi] |
						(cor_reg[gi] & ~(cor_clr_hit & wclr[gi]));
				end
			end
		end
	endgenerate

	// forward every rx tlp, poisoned included
	// poisoned tlps are never dropped here; the application decides
	// what to do with corrupt payload, the poison flag tells it
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_valid_out <= 1'b0;
			rx_hdr_out <= 32'h00000000;
			rx_data_out <= 32'h00000000;
			rx_poisoned_out <= 1'b0;
		end else begin
			rx_valid_out <= rx_valid_in;
			rx_hdr_out <= rx_hdr_in;
			rx_data_out <= rx_data_in;
			rx_poisoned_out <= rx_poison;
		end
	end

	// transmit register; application dropped while config sends
	// limitation: no holding slot for a colliding application tlp,
	// traded for a single-register path with no extra latency
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tx_valid_out <= 1'b0;
			tx_hdr_out <= 32'h00000000;
			tx_data_out <= 32'h00000000;
		end else begin
			tx_valid_out <= tx_sel_cfg | app_tx_valid_in;
			tx_hdr_out <= tx_hdr_sel;
			tx_data_out <= tx_sel_cfg ? cfg_tx_data_in : app_tx_data_in;
		end
	end

	// status copies for the application
	// one cycle behind the registers, as every output is a flop
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			par_en_out <= 1'b0;
			uncor_stat_out <= {`TPE_UNCOR_W{1'b0}};
			cor_stat_out <= {`TPE_COR_W{1'b0}};
		end else begin
			par_en_out <= cmd_reg[`TPE_BIT_PAR_EN];
			uncor_stat_out <= uncor_reg;
			cor_stat_out <= cor_reg;
		end
	end

endmodule // tpe_poison_status

/* File: include/tpe_consts.vh */
/*
 * constants for the poison and error status block: register offsets,
 * field positions, reset values and header bit positions.
 * assumes a 32-bit avalon-mm register bus with byte addresses.
 */
`ifndef TPE_CONSTS_VH
`define TPE_CONSTS_VH

// register byte offsets
`define TPE_OFS_CMD_STAT 4'h0
`define TPE_OFS_UNCOR 4'h4
`define TPE_OFS_COR 4'h8
`define TPE_OFS_CFG_DATA 4'hc

// command/status word fields
`define TPE_BIT_PAR_EN 6
`define TPE_BIT_MDPE 24
`define TPE_BIT_DPE 31
`define TPE_STAT_BIT_MDPE 8
`define TPE_STAT_BIT_DPE 15

// tlp header field positions (first header dword)
`define TPE_HDR_POISON 14
`define TPE_HDR_FMT_HI 31
`define TPE_HDR_FMT_LO 29
`define TPE_HDR_TYPE_HI 28
`define TPE_HDR_TYPE_LO 24

// type codes
`define TPE_TYPE_CPL 5'h0a
`define TPE_TYPE_CFG_LO 5'h04
`define TPE_TYPE_CFG_HI 5'h05
`define TPE_TYPE_MEM 5'h00
`define TPE_TYPE_IO 5'h02

// widths and reset values
`define TPE_UNCOR_W 21
`define TPE_COR_W 16
`define TPE_RST_CMD 32'h00000000
`define TPE_RST_CFG 32'h00000000

`endif

/* File: verif/tpe_link_model.sv */
/* link-side tlp source.
   assumes go_in launched just after a clock edge. */
`timescale 1ns/100ps
module tpe_link_model (
	input wire clk_in,
	input wire rst_n_in,
	input wire go_in,
	input wire [31:0] hdr_in,
	input wire [31:0] dat_in,
	output reg rx_valid_out,
	output reg [31:0] rx_hdr_out,
	output reg [31:0] rx_data_out
);
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rx_valid_out <= 1'b0;
			{rx_hdr_out, rx_data_out} <= 64'h0;
		end else begin
			rx_valid_out <= go_in;
			// stale lines inverted, never held
			rx_hdr_out <= go_in ? hdr_in : ~rx_hdr_out;
			rx_data_out <= go_in ? dat_in : ~rx_data_out;
		end
	end
endmodule // tpe_link_model

/* File: verif/tpe_poison_status_props.sv */
/* port checker for the poison block.
   assumes single clock, async active-low reset. */
`timescale 1ns/100ps
`include "tpe_consts.vh"
module tpe_poison_status_chk (
	input wire clk_sys_in,
	input wire rst_n_in,
	input wire [3:0] avs_address_in,
	input wire avs_write_in,
	input wire rx_valid_in,
	input wire [31:0] rx_hdr_in,
	input wire rx_valid_out,
	input wire [31:0] rx_hdr_out,
	input wire rx_poisoned_out,
	input wire cfg_wr_out,
	input wire app_tx_valid_in,
	input wire [31:0] app_tx_hdr_in,
	input wire cfg_tx_valid_in,
	input wire tx_valid_out,
	input wire [31:0] tx_hdr_out,
	input wire [`TPE_UNCOR_W-1:0] uncor_evt_in,
	input wire [`TPE_UNCOR_W-1:0] uncor_stat_out,
	input wire [`TPE_COR_W-1:0] cor_evt_in,
	input wire [`TPE_COR_W-1:0] cor_stat_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	a_rx_fwd_copy: assert property (
		rx_valid_in |=> rx_valid_out && rx_hdr_out == $past(rx_hdr_in)) else $error("rx lost");
	a_poison_flag: assert property (
		rx_valid_out |-> rx_poisoned_out == rx_hdr_out[14]) else $error("poison flag");
	a_cfg_wr_block: assert property (
		rx_valid_in && rx_hdr_in[14] |=> !cfg_wr_out) else $error("poisoned cfg write");
	a_cfg_tx_clean: assert property (
		cfg_tx_valid_in |=> tx_valid_out && !tx_hdr_out[14]) else $error("cfg tx poisoned");
	a_app_tx_keep: assert property (
		app_tx_valid_in && !cfg_tx_valid_in |=> tx_hdr_out == $past(app_tx_hdr_in))
		else $error("app tx altered");
	a_uncor_set: assert property (
		uncor_evt_in[0] |-> ##2 uncor_stat_out[0]) else $error("uncor not set");
	a_cor_set: assert property (
		cor_evt_in[15] |-> ##2 cor_stat_out[15]) else $error("cor not set");
	a_stat_sticky: assert property (
		$fell(uncor_stat_out[1]) |-> $past(avs_write_in) && $past(avs_address_in) == 4'h4)
		else $error("uncor bit dropped");
endmodule // tpe_poison_status_chk
bind tpe_poison_status tpe_poison_status_chk i_chk (.*);

/* File: verif/tpe_poison_status_tb_top.sv */
/* self-checking bench for the poison block.
   assumes the link model and checker beside it. */
`timescale 1ns/100ps
`include "tpe_consts.vh"
module tpe_poison_status_tb_top;
	reg clk_sys_in = 1'b0;
	reg rst_n_in = 1'b0;
	reg avs_read_in = 1'b0, avs_write_in = 1'b0, go = 1'b0;
	reg app_tx_valid_in = 1'b0, cfg_tx_valid_in = 1'b0;
	reg [3:0] avs_address_in = 4'h0, avs_byteenable_in = 4'hf;
	reg [31:0] avs_writedata_in = 32'h0, go_hdr = 32'h0, go_dat = 32'h0, rd;
	reg [31:0] app_tx_hdr_in = 32'h0, app_tx_data_in = 32'h0;
	reg [31:0] cfg_tx_hdr_in = 32'h0, cfg_tx_data_in = 32'h0;
	reg [`TPE_UNCOR_W-1:0] uncor_evt_in = '0;
	reg [`TPE_COR_W-1:0] cor_evt_in = '0;
	wire avs_waitrequest_out, rx_valid_in, rx_valid_out, rx_poisoned_out, cfg_wr_out;
	wire tx_valid_out, par_en_out;
	wire [31:0] avs_readdata_out, rx_hdr_in, rx_data_in, rx_hdr_out, rx_data_out;
	wire [31:0] cfg_wr_data_out, tx_hdr_out, tx_data_out;
	wire [`TPE_UNCOR_W-1:0] uncor_stat_out;
	wire [`TPE_COR_W-1:0] cor_stat_out;
	integer n_fail = 0, total_checks = 0, cyc = 0;
	integer n_cfg_wr = 0, n_tx = 0;
	reg [31:0] cfg_seen = 32'h0, rx_seen = 32'h0, tx_hdr_seen = 32'h0, tx_dat_seen = 32'h0;
	reg rx_pois_seen = 1'b0;
	// capture one-cycle outputs while they stand
	always @(posedge clk_sys_in) begin
		if (cfg_wr_out) begin
			n_cfg_wr = n_cfg_wr + 1;
			cfg_seen = cfg_wr_data_out;
		end
		if (rx_valid_out) begin
			rx_seen = rx_data_out;
			rx_pois_seen = rx_poisoned_out;
		end
		if (tx_valid_out) begin
			n_tx = n_tx + 1;
			tx_hdr_seen = tx_hdr_out;
			tx_dat_seen = tx_data_out;
		end
	end
	always #25 clk_sys_in = ~clk_sys_in;
	tpe_poison_status i_dut (.*);
	tpe_link_model i_link (.clk_in(clk_sys_in), .rst_n_in(rst_n_in), .go_in(go),
		.hdr_in(go_hdr), .dat_in(go_dat), .rx_valid_out(rx_valid_in),
		.rx_hdr_out(rx_hdr_in), .rx_data_out(rx_data_in));
	task end_sim;
		begin
			if (n_fail == 0 && total_checks > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// one avalon access, held until waitrequest seen low
	task acc(input w, input [3:0] a, input [31:0] d);
		begin
			@(posedge clk_sys_in);
			avs_read_in <= !w;
			avs_write_in <= w;
			avs_address_in <= a;
			avs_writedata_in <= d;
			@(posedge clk_sys_in);
			while (avs_waitrequest_out !== 1'b0) @(posedge clk_sys_in);
			rd = avs_readdata_out;
			avs_read_in <= 1'b0;
			avs_write_in <= 1'b0;
		end
	endtask
	task rdc(input [3:0] a, input [31:0] e);
		begin
			acc(1'b0, a, 32'h0);
			total_checks = total_checks + 1;
			if (rd !== e) begin
				n_fail = n_fail + 1;
				$display("MISMATCH reg %h exp %h got %h", a, e, rd);
			end
		end
	endtask
	task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
		begin
			total_checks = total_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("MISMATCH %s exp %h got %h", nm, e, g);
			end
		end
	endtask
	// one tlp from the link, then time to settle
	task tlp(input [31:0] h, input [31:0] d);
		begin
			@(posedge clk_sys_in);
			go <= 1'b1;
			go_hdr <= h;
			go_dat <= d;
			@(posedge clk_sys_in);
			go <= 1'b0;
			repeat (3) @(posedge clk_sys_in);
		end
	endtask
	// hang guard, far beyond the sequence length
	always @(posedge clk_sys_in) begin
		cyc = cyc + 1;
		if (cyc > 2000) begin
			n_fail = n_fail + 1;
			end_sim;
		end
	end
	initial begin
		repeat (3) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		rdc(4'h4, 32'h0);
		rdc(4'h8, 32'h0);
		acc(1'b1, 4'h0, 32'h00000040);
		tlp(32'h4a004000, 32'h0);
		rdc(4'h0, 32'h81000040);
		chk("paren", 32'h1, {31'h0, par_en_out});
		acc(1'b1, 4'h0, 32'h81000040);
		rdc(4'h0, 32'h00000040);
		@(posedge clk_sys_in);
		app_tx_valid_in <= 1'b1;
		app_tx_hdr_in <= 32'h40004000;
		@(posedge clk_sys_in);
		app_tx_valid_in <= 1'b0;
		cfg_tx_valid_in <= 1'b1;
		cfg_tx_hdr_in <= 32'h4a004000;
		cfg_tx_data_in <= 32'h000000c3;
		@(posedge clk_sys_in);
		cfg_tx_valid_in <= 1'b0;
		rdc(4'h0, 32'h01000040);
		chk("txcount", 32'h2, n_tx);
		chk("txhdr", 32'h4a000000, tx_hdr_seen);
		chk("txdata", 32'h000000c3, tx_dat_seen);
		acc(1'b1, 4'h0, 32'h01000000);
		tlp(32'h44000000, 32'h0000005a);
		tlp(32'h44004000, 32'h00001234);
		rdc(4'hc, 32'h0000005a);
		chk("cfgwrn", 32'h1, n_cfg_wr);
		chk("cfgwrd", 32'h0000005a, cfg_seen);
		chk("rxdata", 32'h00001234, rx_seen);
		chk("rxpois", 32'h1, {31'h0, rx_pois_seen});
		rdc(4'h0, 32'h80000000);
		@(posedge clk_sys_in);
		uncor_evt_in <= '1;
		cor_evt_in <= '1;
		@(posedge clk_sys_in);
		uncor_evt_in <= 21'h000002;
		cor_evt_in <= '0;
		acc(1'b1, 4'h4, 32'h001fffff);
		@(posedge clk_sys_in);
		uncor_evt_in <= '0;
		rdc(4'h4, 32'h00000002);
		rdc(4'h8, 32'h0000ffff);
		acc(1'b1, 4'h8, 32'h0000ff00);
		rdc(4'h8, 32'h000000ff);
		acc(1'b1, 4'h4, 32'h00000002);
		rdc(4'h4, 32'h0);
		end_sim;
	end
endmodule // tpe_poison_status_tb_top
